// ### anc_ctrl_monitor.sv
// assertion checker for the upper control register bank
// assumes strobes are taken on the rising edge and controls follow a write two edges later
`timescale 1ns/1ps
`default_nettype none
module anc_ctrl_monitor
  import anc_ctrl_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       evaluation_access_enable,
  input wire logic       power_keep_bit,
  input wire logic [5:0] left_gain_code,
  input wire logic       mic_supply_pump_disable,
  input wire logic       bypass_switch_hold_off,
  input wire logic       mic_supply_disconnect,
  input wire logic       headphone_amp_disable,
  input wire logic       headphone_output_config,
  input wire logic       serial_power_down,
  input wire logic       line_master_mute,
  input wire otp_op_e    otp_operation
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire w31 = reg_write && reg_addr == ADDR_LEFT_GAIN;
  wire w34 = reg_write && reg_addr == ADDR_POWER;
  wire w35 = reg_write && reg_addr == ADDR_OUTPUT;
  wire w3d = reg_write && reg_addr == ADDR_EVALUATION_OVERRIDES;
  wire w3f = reg_write && reg_addr == ADDR_OTP_ACCESS;
  chk_left_gain: assert property (w31 |-> ##2 left_gain_code == $past(reg_wdata[5:0], 2))
    else $error("left gain code does not follow write");
  chk_pump_bypass: assert property (w34 |-> ##2 (bypass_switch_hold_off == !$past(reg_wdata[7], 2))
    && (bypass_switch_hold_off != mic_supply_pump_disable))
    else $error("bypass hold does not mirror pump disable");
  chk_supply_rise: assert property ($rose(mic_supply_disconnect) |-> $past(w34 && reg_wdata[5], 2))
    else $error("supply disconnect rose without a write");
  chk_hph_disable: assert property (w34 |-> ##2 headphone_amp_disable == $past(reg_wdata[0], 2))
    else $error("headphone disable does not follow write");
  chk_mode_change: assert property ($changed(headphone_output_config) |-> $past(w35, 2))
    else $error("headphone mode changed without a write");
  chk_serial_pd: assert property (w35 ##1 !power_keep_bit |-> ##1 serial_power_down == $past(reg_wdata[0], 2))
    else $error("serial power down wrong");
  chk_line_mute: assert property (w3d |-> ##2 line_master_mute == $past(reg_wdata[4], 2))
    else $error("line master mute does not follow write");
  chk_otp_gate: assert property (w3f |-> ##2
    otp_operation == ($past(evaluation_access_enable, 2) ? $past(reg_wdata[1:0], 2) : $past(otp_operation)))
    else $error("otp operation gated wrongly");
endmodule
bind anc_driver_control_regs anc_ctrl_monitor mon (
  .clock(clock), .sys_rst(sys_rst), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .evaluation_access_enable(evaluation_access_enable), .power_keep_bit(power_keep_bit),
  .left_gain_code(left_gain_code), .mic_supply_pump_disable(mic_supply_pump_disable),
  .bypass_switch_hold_off(bypass_switch_hold_off), .mic_supply_disconnect(mic_supply_disconnect),
  .headphone_amp_disable(headphone_amp_disable), .headphone_output_config(headphone_output_config),
  .serial_power_down(serial_power_down), .line_master_mute(line_master_mute), .otp_operation(otp_operation)
);
`default_nettype wire

// ### anc_ctrl_pkg.sv
// constants for the upper control register bank
// assumes an 8-bit register address and 8-bit data from the serial front end
package anc_ctrl_pkg;

  localparam logic [7:0] ADDR_LEFT_GAIN   = 8'h31;
  localparam logic [7:0] ADDR_RIGHT_MON   = 8'h32;
  localparam logic [7:0] ADDR_LEFT_MON    = 8'h33;
  localparam logic [7:0] ADDR_POWER       = 8'h34;
  localparam logic [7:0] ADDR_OUTPUT      = 8'h35;
  localparam logic [7:0] ADDR_EVALUATION_OVERRIDES        = 8'h3D;
  localparam logic [7:0] ADDR_OTP_CLOCK   = 8'h3E;
  localparam logic [7:0] ADDR_OTP_ACCESS  = 8'h3F;

  localparam logic [7:0] RST_LEFT_GAIN    = 8'h80;
  localparam logic [7:0] RST_ZERO         = 8'h00;

  // writable bit masks; other positions read zero
  localparam logic [7:0] MASK_GAIN        = 8'h3F;
  localparam logic [7:0] MASK_LEFT_GAIN   = 8'hBF;
  localparam logic [7:0] MASK_POWER       = 8'hB7;
  localparam logic [7:0] MASK_OUTPUT      = 8'h8F;
  localparam logic [7:0] MASK_EVALUATION_OVERRIDES        = 8'h1F;
  localparam logic [7:0] MASK_OTP_CLOCK   = 8'h08;
  localparam logic [7:0] MASK_OTP_ACCESS  = 8'h3F;

  // power register bits
  localparam int BIT_PUMP_DIS   = 7;
  localparam int BIT_SUPPLY_OFF = 5;
  localparam int BIT_AGC_EN     = 4;
  localparam int BIT_PREAMP_PD  = 2;
  localparam int BIT_NEG_DIS    = 1;
  localparam int BIT_HPH_DIS    = 0;
  // output config bits
  localparam int BIT_DISCH_DIS  = 3;
  localparam int BIT_MUX_DELAY  = 2;
  localparam int BIT_HPH_DIFF   = 1;
  localparam int BIT_SER_PD     = 0;
  // evaluation bits
  localparam int BIT_LIN_MUTE   = 4;
  localparam int BIT_MON_FORCE  = 3;
  localparam int BIT_PBO_FORCE  = 2;
  localparam int BIT_R_MUTE     = 1;
  localparam int BIT_L_MUTE     = 0;
  // otp bits
  localparam int BIT_EXT_CLK    = 3;
  localparam int BIT_BANK_SEL   = 5;
  localparam int BIT_BUF_SW     = 4;
  localparam int BIT_UPPER_EN   = 3;
  localparam int BIT_LOWER_EN   = 2;

  typedef enum logic [1:0] {
    OTP_READ  = 2'b00,
    OTP_LOAD  = 2'b01,
    OTP_WRITE = 2'b10,
    OTP_BURN  = 2'b11
  } otp_op_e;

endpackage

// ### anc_driver_control_regs.sv
// upper control register bank (0x31..0x3F) of the headset driver
// assumes the serial front end presents one-cycle write/read strobes with address and data
`timescale 1ns/1ps
`default_nettype none

module anc_driver_control_regs
  import anc_ctrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       evaluation_access_enable,
  input  wire logic       power_keep_bit,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [5:0] left_gain_code,
  output logic      [5:0] right_monitor_gain_code,
  output logic      [5:0] left_monitor_gain_code,
  output logic            mic_supply_pump_disable,
  output logic            bypass_switch_hold_off,
  output logic            mic_supply_disconnect,
  output logic            preamp_gain_control_enable,
  output logic            preamp_power_down,
  output logic            negative_pump_disable,
  output logic            headphone_amp_disable,
  output logic            supply_discharge_disable,
  output logic            startup_mux_delay,
  output logic            headphone_output_config,
  output logic            serial_power_down,
  output logic            line_master_mute,
  output logic            monitor_force,
  output logic            playback_only_force,
  output logic            right_mic_master_silence,
  output logic            left_mic_master_silence,
  output logic            external_program_clock_select,
  output logic            bank_select,
  output logic            program_buffer_switch,
  output logic            upper_pair_enable,
  output logic            lower_quad_enable,
  output otp_op_e         otp_operation
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] left_mic_gain_reg;
  logic [7:0] right_mic_monitor_gain_reg;
  logic [7:0] left_mic_monitor_gain_reg;
  logic [7:0] power_block_control_reg;
  logic [7:0] output_config_reg;
  logic [7:0] evaluation_overrides_reg;
  logic [7:0] otp_clock_config_reg;
  logic [7:0] otp_access_control_reg;

  function automatic logic is_otp_addr(input logic [7:0] a);
    is_otp_addr = (a == ADDR_OTP_CLOCK) || (a == ADDR_OTP_ACCESS);
  endfunction

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // otp registers locked until access enable; test bit 7 kept at reset value
  // because a write there is forbidden and cannot be trusted
  logic wr_ok;
  assign wr_ok = reg_write && (!is_otp_addr(reg_addr) || evaluation_access_enable);

  // one enable per register so each storage process owns a single concern
  logic wr_left_gain;
  logic wr_right_mon;
  logic wr_left_mon;
  logic wr_power;
  logic wr_output;
  logic wr_evaluation_overrides;
  logic wr_otp_clock;
  logic wr_otp_access;

  assign wr_left_gain  = wr_ok && (reg_addr == ADDR_LEFT_GAIN);
  assign wr_right_mon  = wr_ok && (reg_addr == ADDR_RIGHT_MON);
  assign wr_left_mon   = wr_ok && (reg_addr == ADDR_LEFT_MON);
  assign wr_power      = wr_ok && (reg_addr == ADDR_POWER);
  assign wr_output     = wr_ok && (reg_addr == ADDR_OUTPUT);
  assign wr_evaluation_overrides       = wr_ok && (reg_addr == ADDR_EVALUATION_OVERRIDES);
  assign wr_otp_clock  = wr_ok && (reg_addr == ADDR_OTP_CLOCK);
  assign wr_otp_access = wr_ok && (reg_addr == ADDR_OTP_ACCESS);

  // ----------------------------------------
  // register write processes
  // ----------------------------------------
  // test bit forced back to one on every write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      left_mic_gain_reg <= RST_LEFT_GAIN;
    end else if (wr_left_gain) begin
      left_mic_gain_reg <= (reg_wdata & MASK_GAIN) | RST_LEFT_GAIN;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      right_mic_monitor_gain_reg <= RST_ZERO;
    end else if (wr_right_mon) begin
      right_mic_monitor_gain_reg <= reg_wdata & MASK_GAIN;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      left_mic_monitor_gain_reg <= RST_ZERO;
    end else if (wr_left_mon) begin
      left_mic_monitor_gain_reg <= reg_wdata & MASK_GAIN;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      power_block_control_reg <= RST_ZERO;
    end else if (wr_power) begin
      power_block_control_reg <= reg_wdata & MASK_POWER;
    end
  end

  // test bit 7 is never stored; the read path supplies it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      output_config_reg <= RST_ZERO;
    end else if (wr_output) begin
      output_config_reg <= reg_wdata & (MASK_OUTPUT & 8'h0F);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      evaluation_overrides_reg <= RST_ZERO;
    end else if (wr_evaluation_overrides) begin
      evaluation_overrides_reg <= reg_wdata & MASK_EVALUATION_OVERRIDES;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      otp_clock_config_reg <= RST_ZERO;
    end else if (wr_otp_clock) begin
      otp_clock_config_reg <= reg_wdata & MASK_OTP_CLOCK;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      otp_access_control_reg <= RST_ZERO;
    end else if (wr_otp_access) begin
      otp_access_control_reg <= reg_wdata & MASK_OTP_ACCESS;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // output config test bit reads as its reset value of one
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_LEFT_GAIN:  rd_mux = left_mic_gain_reg;
      ADDR_RIGHT_MON:  rd_mux = right_mic_monitor_gain_reg;
      ADDR_LEFT_MON:   rd_mux = left_mic_monitor_gain_reg;
      ADDR_POWER:      rd_mux = power_block_control_reg;
      ADDR_OUTPUT:     rd_mux = output_config_reg | 8'h80;
      ADDR_EVALUATION_OVERRIDES:       rd_mux = evaluation_overrides_reg;
      ADDR_OTP_CLOCK:  rd_mux = evaluation_access_enable ? otp_clock_config_reg : RST_ZERO;
      ADDR_OTP_ACCESS: rd_mux = evaluation_access_enable ? otp_access_control_reg : RST_ZERO;
      default:         rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata  <= RST_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // gain code outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      left_gain_code          <= 6'h00;
      right_monitor_gain_code <= 6'h00;
      left_monitor_gain_code  <= 6'h00;
    end else begin
      left_gain_code          <= left_mic_gain_reg[5:0];
      right_monitor_gain_code <= right_mic_monitor_gain_reg[5:0];
      left_monitor_gain_code  <= left_mic_monitor_gain_reg[5:0];
    end
  end

  // ----------------------------------------
  // power block outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mic_supply_pump_disable <= 1'b0;
      bypass_switch_hold_off  <= 1'b1;
    end else begin
      mic_supply_pump_disable <= power_block_control_reg[BIT_PUMP_DIS];
      // the running pump is what keeps the bypass switch off; disabling it frees the switch
      bypass_switch_hold_off  <= !power_block_control_reg[BIT_PUMP_DIS];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mic_supply_disconnect <= 1'b0;
    end else begin
      mic_supply_disconnect <= power_block_control_reg[BIT_SUPPLY_OFF];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      preamp_gain_control_enable <= 1'b0;
    end else begin
      preamp_gain_control_enable <= power_block_control_reg[BIT_AGC_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      preamp_power_down <= 1'b0;
    end else begin
      preamp_power_down <= power_block_control_reg[BIT_PREAMP_PD];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      negative_pump_disable <= 1'b0;
      headphone_amp_disable <= 1'b0;
    end else begin
      negative_pump_disable <= power_block_control_reg[BIT_NEG_DIS];
      headphone_amp_disable <= power_block_control_reg[BIT_HPH_DIS];
    end
  end

  // ----------------------------------------
  // output configuration outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      supply_discharge_disable <= 1'b0;
    end else begin
      supply_discharge_disable <= output_config_reg[BIT_DISCH_DIS];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      startup_mux_delay <= 1'b0;
    end else begin
      startup_mux_delay <= output_config_reg[BIT_MUX_DELAY];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      headphone_output_config <= 1'b0;
    end else begin
      headphone_output_config <= output_config_reg[BIT_HPH_DIFF];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_power_down <= 1'b0;
    end else begin
      // power down path only when enabled and keep bit released
      serial_power_down <= output_config_reg[BIT_SER_PD] && !power_keep_bit;
    end
  end

  // ----------------------------------------
  // evaluation override outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_master_mute <= 1'b0;
    end else begin
      line_master_mute <= evaluation_overrides_reg[BIT_LIN_MUTE];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      monitor_force       <= 1'b0;
      playback_only_force <= 1'b0;
    end else begin
      monitor_force       <= evaluation_overrides_reg[BIT_MON_FORCE];
      playback_only_force <= evaluation_overrides_reg[BIT_PBO_FORCE];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      right_mic_master_silence <= 1'b0;
      left_mic_master_silence  <= 1'b0;
    end else begin
      right_mic_master_silence <= evaluation_overrides_reg[BIT_R_MUTE];
      left_mic_master_silence  <= evaluation_overrides_reg[BIT_L_MUTE];
    end
  end

  // ----------------------------------------
  // otp control outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      external_program_clock_select <= 1'b0;
    end else begin
      external_program_clock_select <= otp_clock_config_reg[BIT_EXT_CLK];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bank_select           <= 1'b0;
      program_buffer_switch <= 1'b0;
    end else begin
      bank_select           <= otp_access_control_reg[BIT_BANK_SEL];
      program_buffer_switch <= otp_access_control_reg[BIT_BUF_SW];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      upper_pair_enable <= 1'b0;
      lower_quad_enable <= 1'b0;
    end else begin
      upper_pair_enable <= otp_access_control_reg[BIT_UPPER_EN];
      lower_quad_enable <= otp_access_control_reg[BIT_LOWER_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      otp_operation <= OTP_READ;
    end else begin
      otp_operation <= otp_op_e'(otp_access_control_reg[1:0]);
    end
  end

endmodule

`default_nettype wire

// ### mcu_host_model.sv
// microcontroller model driving the bank's register strobe port
// assumes one shared clock; the bench holds reset before the first call
`timescale 1ns/1ps
`default_nettype none
module mcu_host_model
  import anc_ctrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            evaluation_access_enable,
  output logic            power_keep_bit
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    evaluation_access_enable = 1'b0;
    power_keep_bit = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == ADDR_LEFT_GAIN || a == ADDR_OUTPUT) ? (d & 8'h7F) : d;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clock);
      ok = (reg_rvalid === 1'b1);
      d = reg_rdata;
    end
  endtask
  // otp registers only opened once evaluation access is raised
  task automatic set_levels(input logic ena, input logic keep);
    @(posedge clock);
    evaluation_access_enable <= ena;
    power_keep_bit <= keep;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the control register bank with its host model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import anc_ctrl_pkg::*;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  int         errors = 0;
  int         cmp_count = 0;
  logic       reg_write, reg_read, evaluation_access_enable, power_keep_bit, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] left_gain_code, right_monitor_gain_code, left_monitor_gain_code;
  logic       mic_supply_pump_disable, bypass_switch_hold_off, mic_supply_disconnect, preamp_gain_control_enable;
  logic       preamp_power_down, negative_pump_disable, headphone_amp_disable, supply_discharge_disable;
  logic       startup_mux_delay, headphone_output_config, serial_power_down, line_master_mute, monitor_force;
  logic       playback_only_force, right_mic_master_silence, left_mic_master_silence, external_program_clock_select;
  logic       bank_select, program_buffer_switch, upper_pair_enable, lower_quad_enable;
  otp_op_e    otp_operation;
  anc_driver_control_regs dut (.*);
  mcu_host_model host (.*);
  always #2.5 clock = ~clock;
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    cmp("read valid", 24'h1, {23'h0, ok});
    cmp("read data", {16'h0, exp}, {16'h0, d});
  endtask
  task automatic t_reset();
    logic [7:0] a [10] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3D, 8'h3E, 8'h3F, 8'h30, 8'h36};
    host.wr(8'h36, 8'hFF);
    for (int i = 0; i < 10; i++)
      rd_cmp(a[i], (a[i] == 8'h31 || a[i] == 8'h35) ? 8'h80 : 8'h00);
    cmp("bypass hold", 24'h1, {23'h0, bypass_switch_hold_off});
  endtask
  task automatic t_gains();
    logic [7:0] v [4] = '{8'h00, 8'h01, 8'h3F, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_LEFT_GAIN, v[i]);
      host.wr(ADDR_RIGHT_MON, v[i] ^ 8'h3F);
      host.wr(ADDR_LEFT_MON, ~v[i]);
      rd_cmp(ADDR_LEFT_GAIN, 8'h80 | (v[i] & 8'h3F));
      rd_cmp(ADDR_RIGHT_MON, (v[i] ^ 8'h3F) & 8'h3F);
      rd_cmp(ADDR_LEFT_MON, ~v[i] & 8'h3F);
      cmp("gain codes", {6'h0, v[i][5:0], v[i][5:0] ^ 6'h3F, ~v[i][5:0]},
          {6'h0, left_gain_code, right_monitor_gain_code, left_monitor_gain_code});
    end
  endtask
  task automatic t_power();
    host.wr(ADDR_POWER, 8'hFF);
    rd_cmp(ADDR_POWER, 8'hB7);
    cmp("power controls", 24'hB7, {16'h0, mic_supply_pump_disable, 1'b0, mic_supply_disconnect,
        preamp_gain_control_enable, 1'b0, preamp_power_down, negative_pump_disable, headphone_amp_disable});
    cmp("bypass hold", 24'h0, {23'h0, bypass_switch_hold_off});
    host.wr(ADDR_POWER, 8'h20);
    rd_cmp(ADDR_POWER, 8'h20);
    cmp("supply and bypass", 24'h3, {22'h0, mic_supply_disconnect, bypass_switch_hold_off});
  endtask
  task automatic t_output();
    host.wr(ADDR_OUTPUT, 8'hFF);
    rd_cmp(ADDR_OUTPUT, 8'h8F);
    cmp("output controls", 24'hF, {20'h0, supply_discharge_disable, startup_mux_delay,
        headphone_output_config, serial_power_down});
    host.set_levels(1'b0, 1'b1);
    repeat (2) @(posedge clock);
    cmp("serial power down", 24'h0, {23'h0, serial_power_down});
    host.set_levels(1'b0, 1'b0);
    host.wr(ADDR_OUTPUT, 8'h00);
    rd_cmp(ADDR_OUTPUT, 8'h80);
    cmp("output cleared", 24'h0, {22'h0, headphone_output_config, serial_power_down});
  endtask
  task automatic t_evaluation_overrides();
    for (int i = 0; i < 5; i++) begin
      host.wr(ADDR_EVALUATION_OVERRIDES, (8'h01 << i) | 8'hE0);
      rd_cmp(ADDR_EVALUATION_OVERRIDES, 8'h01 << i);
      cmp("overrides", 24'h1 << i, {19'h0, line_master_mute, monitor_force, playback_only_force,
          right_mic_master_silence, left_mic_master_silence});
    end
  endtask
  task automatic t_otp();
    logic [7:0] v;
    host.wr(ADDR_OTP_ACCESS, 8'h3F);
    host.set_levels(1'b1, 1'b1);
    rd_cmp(ADDR_OTP_ACCESS, 8'h00);
    host.wr(ADDR_OTP_CLOCK, 8'hFF);
    rd_cmp(ADDR_OTP_CLOCK, 8'h08);
    for (int i = 0; i < 4; i++) begin
      v = 8'hC0 | (8'h04 << i) | 8'(i);
      host.wr(ADDR_OTP_ACCESS, v);
      rd_cmp(ADDR_OTP_ACCESS, v & 8'h3F);
      cmp("otp controls", {16'h0, v & 8'h3F} | 24'h80,
          {16'h0, external_program_clock_select, 1'b0, bank_select, program_buffer_switch,
          upper_pair_enable, lower_quad_enable, otp_operation});
    end
    host.set_levels(1'b0, 1'b0);
    host.wr(ADDR_OTP_ACCESS, 8'h00);
    rd_cmp(ADDR_OTP_ACCESS, 8'h00);
    host.set_levels(1'b1, 1'b0);
    rd_cmp(ADDR_OTP_ACCESS, 8'h23);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_gains();
    t_power();
    t_output();
    t_evaluation_overrides();
    t_otp();
    tally_and_finish();
  end
endmodule
`default_nettype wire
